//--- vim_pkg.sv
// What this block does
// - Mailbox access asserts the selected interrupt output
// - Mapping zero drives dedicated output; strap picks role
// - Mapping one to seven drives matching host line
// - Three-bit mapping, writable and readable
// - Enabled VMEbus level N drives host line N
// - Forward setting uses low three bits; 255 disables
// - Rerun count five bits, default zero
// - Fair mode setting steers requester, default true
// - One enable gates all non-maskable sources
// - Writing watchdog period never starts counting
// - Mailbox byte writable and readable by host
// - Running watchdog cannot be stopped, only restarted
package vim_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned LEVELS = 7;
  localparam int unsigned MAP_W = 3;
  localparam int unsigned RERUN_W = 5;
  localparam int unsigned WD_W = 16;
  localparam int unsigned EVT_W = 5;

  localparam logic [ADDR_W-1:0] ADR_MAILBOX = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_MAP = 4'h1;
  localparam logic [ADDR_W-1:0] ADR_FWD_BASE = 4'h1;
  localparam logic [ADDR_W-1:0] ADR_CTRL = 4'h9;
  localparam logic [ADDR_W-1:0] ADR_RERUN = 4'hA;
  localparam logic [ADDR_W-1:0] ADR_WD_LO = 4'hB;
  localparam logic [ADDR_W-1:0] ADR_WD_HI = 4'hC;
  localparam logic [ADDR_W-1:0] ADR_STATUS = 4'hD;
  localparam logic [ADDR_W-1:0] ADR_MASK = 4'hE;
  localparam logic [ADDR_W-1:0] ADR_STATE = 4'hF;

  localparam int unsigned CTRL_FAIR = 0;
  localparam int unsigned CTRL_NMI_EN = 1;
  localparam int unsigned CTRL_WD_START = 2;
  localparam int unsigned CTRL_SF_REL = 3;

  localparam int unsigned EV_MBOX = 0;
  localparam int unsigned EV_WD = 1;
  localparam int unsigned EV_ABORT = 2;
  localparam int unsigned EV_SYSFAIL = 3;
  localparam int unsigned EV_ACFAIL = 4;

  localparam int unsigned ST_WD_RUN = 0;
  localparam int unsigned ST_STRAP = 1;
  localparam int unsigned ST_SF_DRIVE = 2;

  localparam logic [DATA_W-1:0] RST_FWD = 8'hFF;
  localparam logic [MAP_W-1:0] RST_MAP = 3'h0;
  localparam logic [RERUN_W-1:0] RST_RERUN = 5'h00;
  localparam logic RST_FAIR = 1'b1;
  localparam logic RST_NMI_EN = 1'b1;
  localparam logic [WD_W-1:0] RST_WD = 16'hFFFF;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned WD_TICK_US = 1;
  localparam int unsigned WD_TICK_CYC = (CLK_HZ / 1_000_000) * WD_TICK_US;

  typedef enum logic [1:0] {VIM_WD_IDLE, VIM_WD_RUN} vim_wd_state_t;
endpackage

//--- vim_sync.sv
`timescale 1ns/1ns
module vim_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= INIT;
      sync_out <= INIT;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

//--- vim_watchdog.sv
`timescale 1ns/1ns
module vim_watchdog
  import vim_pkg::*;
#(
  parameter int unsigned TICK_CYC = vim_pkg::WD_TICK_CYC
) (
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     start_in,
  input  wire logic [vim_pkg::WD_W-1:0] period_in,
  output logic                          running_out,
  output logic                          half_out,
  output logic                          expire_out
);
  vim_wd_state_t    state;
  logic [15:0]      pre;
  logic [WD_W-1:0]  count;
  logic [WD_W-1:0]  limit;
  logic             tick;

  assign tick = (pre == 16'(TICK_CYC - 1));

  // Period is latched only on start, so later writes wait for a restart
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= VIM_WD_IDLE;
      pre <= 16'h0000;
      count <= '0;
      limit <= '0;
    end else begin
      case (state)
        VIM_WD_IDLE: begin
          if (start_in) begin
            state <= VIM_WD_RUN;
            limit <= period_in;
            pre <= 16'h0000;
            count <= '0;
          end
        end
        VIM_WD_RUN: begin
          // No path back to idle: stopping is not possible
          if (start_in) begin
            limit <= period_in;
            pre <= 16'h0000;
            count <= '0;
          end else if (tick) begin
            pre <= 16'h0000;
            count <= (count >= limit) ? '0 : count + 1'b1;
          end else begin
            pre <= pre + 16'h0001;
          end
        end
        default: state <= VIM_WD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      running_out <= 1'b0;
      half_out <= 1'b0;
      expire_out <= 1'b0;
    end else begin
      running_out <= (state == VIM_WD_RUN);
      half_out <= (state == VIM_WD_RUN) && !start_in && tick
                  && (count == (limit >> 1));
      expire_out <= (state == VIM_WD_RUN) && !start_in && tick
                    && (count == limit);
    end
  end
endmodule

//--- vim_router.sv
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
module vim_router
  import vim_pkg::*;
#(
  parameter int unsigned WD_TICK = vim_pkg::WD_TICK_CYC
) (
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_n_in,
  input  wire logic [vim_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [vim_pkg::DATA_W-1:0]  reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic      [vim_pkg::DATA_W-1:0]  reg_rdata_out,
  input  wire logic [vim_pkg::LEVELS:1]    vme_irq_n_in,
  input  wire logic                        vme_mbox_acc_in,
  input  wire logic                        vme_mbox_we_in,
  input  wire logic [vim_pkg::DATA_W-1:0]  vme_mbox_wdata_in,
  output logic      [vim_pkg::DATA_W-1:0]  vme_mbox_rdata_out,
  input  wire logic                        abort_n_in,
  input  wire logic                        acfail_n_in,
  input  wire logic                        sysfail_n_in,
  output logic                             sysfail_n_out,
  output logic                             sysfail_oe_n_out,
  input  wire logic                        mbox_strap_in,
  output logic      [vim_pkg::LEVELS:1]    host_irq_line_n_out,
  output logic                             mailbox_special_irq_n_out,
  output logic                             mbox_reset_n_out,
  output logic                             nmi_n_out,
  output logic                             wd_reset_n_out,
  output logic                             req_fair_out,
  output logic      [vim_pkg::RERUN_W-1:0] rerun_count_out,
  output logic                             irq_out
);
  localparam int unsigned SYNC_W = LEVELS + 5 + DATA_W;

  logic [SYNC_W-1:0]  pins_raw;
  logic [SYNC_W-1:0]  pins_sync;
  logic [LEVELS:1]    vme_req;
  logic               mbox_acc;
  logic               mbox_acc_d;
  logic               mbox_we;
  logic               abort_act;
  logic               acfail_act;
  logic               sysfail_act;
  logic               strap_s;
  logic [DATA_W-1:0]  mbox_wdata_s;
  logic [1:0]         strap_wait;
  logic               mbox_evt;

  logic [DATA_W-1:0]  mailbox;
  logic [MAP_W-1:0]   mbox_map;
  logic [DATA_W-1:0]  fwd_cfg [1:LEVELS];
  logic [LEVELS:1]    fwd_en;
  logic               fair_mode;
  logic               nmi_en;
  logic               sf_drive;
  logic [RERUN_W-1:0] rerun;
  logic [WD_W-1:0]    wd_period;
  logic               wd_start;
  logic               wd_run;
  logic               wd_half;
  logic               wd_expire;
  logic [EVT_W-1:0]   status;
  logic [EVT_W-1:0]   mask;
  logic [EVT_W-1:0]   evt_set;
  logic [EVT_W-1:0]   evt_clr;
  logic               strap_reset;
  logic               strap_done;
  logic               wr_hit;
  logic [LEVELS:1]    next_host_n;
  logic [DATA_W-1:0]  next_rdata;
  logic               nmi_src;

  // Pins from the backplane and front panel come from other timing
  assign pins_raw = {vme_mbox_wdata_in, mbox_strap_in, vme_mbox_we_in, vme_mbox_acc_in,
                     abort_n_in, acfail_n_in, vme_irq_n_in};

  vim_sync #(
    .WIDTH (SYNC_W),
    .INIT  ({{DATA_W{1'b0}}, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, {LEVELS{1'b1}}})
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (pins_raw),
    .sync_out   (pins_sync)
  );

  assign vme_req = ~pins_sync[LEVELS-1:0];
  assign acfail_act = ~pins_sync[LEVELS];
  assign abort_act = ~pins_sync[LEVELS+1];
  assign mbox_acc = pins_sync[LEVELS+2];
  assign mbox_we = pins_sync[LEVELS+3];
  assign strap_s = pins_sync[LEVELS+4];
  assign mbox_wdata_s = pins_sync[SYNC_W-1:LEVELS+5];

  vim_sync #(
    .WIDTH (1),
    .INIT  (1'b1)
  ) u_sync_sf (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (sysfail_n_in),
    .sync_out   (sysfail_act)
  );

  // Strap caught once the synchroniser holds the pin; later changes ignored
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_wait <= 2'h0;
      strap_done <= 1'b0;
      strap_reset <= 1'b0;
    end else if (!strap_done && strap_wait == 2'h2) begin
      strap_done <= 1'b1;
      strap_reset <= strap_s;
    end else if (!strap_done) begin
      strap_wait <= strap_wait + 2'h1;
    end
  end

  // One event per VMEbus access, on the rising edge of the strobe
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mbox_acc_d <= 1'b0;
    end else begin
      mbox_acc_d <= mbox_acc;
    end
  end

  assign mbox_evt = mbox_acc && !mbox_acc_d;
  assign wr_hit = reg_wr_in;

  // Mailbox byte: host writes, VMEbus writes on access with write set
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mailbox <= '0;
    end else if (mbox_evt && mbox_we) begin
      mailbox <= mbox_wdata_s;
    end else if (wr_hit && reg_addr_in == ADR_MAILBOX) begin
      mailbox <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vme_mbox_rdata_out <= '0;
    end else begin
      vme_mbox_rdata_out <= mailbox;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mbox_map <= RST_MAP;
    end else if (wr_hit && reg_addr_in == ADR_MAP) begin
      mbox_map <= reg_wdata_in[MAP_W-1:0];
    end
  end

  // Per-level forwarding settings, one register each
  genvar g;
  generate
    for (g = 1; g <= LEVELS; g++) begin : g_fwd
      always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          fwd_cfg[g] <= RST_FWD;
        end else if (wr_hit && reg_addr_in == ADR_FWD_BASE + ADDR_W'(g)) begin
          fwd_cfg[g] <= reg_wdata_in;
        end
      end
      // All-ones means off, else only the low bits matter
      assign fwd_en[g] = (fwd_cfg[g] != RST_FWD)
                         && (fwd_cfg[g][MAP_W-1:0] == MAP_W'(g));
    end
  endgenerate

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fair_mode <= RST_FAIR;
      nmi_en <= RST_NMI_EN;
    end else if (wr_hit && reg_addr_in == ADR_CTRL) begin
      fair_mode <= reg_wdata_in[CTRL_FAIR];
      nmi_en <= reg_wdata_in[CTRL_NMI_EN];
    end
  end

  // SYSFAIL is driven from reset until software lets it go
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sf_drive <= 1'b1;
    end else if (wr_hit && reg_addr_in == ADR_CTRL
                 && reg_wdata_in[CTRL_SF_REL]) begin
      sf_drive <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sysfail_n_out <= 1'b1;
      sysfail_oe_n_out <= 1'b1;
    end else begin
      sysfail_n_out <= 1'b0;
      sysfail_oe_n_out <= !sf_drive;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rerun <= RST_RERUN;
    end else if (wr_hit && reg_addr_in == ADR_RERUN) begin
      rerun <= reg_wdata_in[RERUN_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_fair_out <= RST_FAIR;
      rerun_count_out <= RST_RERUN;
    end else begin
      req_fair_out <= fair_mode;
      rerun_count_out <= rerun;
    end
  end

  // Watchdog period: storing it alone leaves the counter idle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wd_period <= RST_WD;
    end else if (wr_hit && reg_addr_in == ADR_WD_LO) begin
      wd_period[DATA_W-1:0] <= reg_wdata_in;
    end else if (wr_hit && reg_addr_in == ADR_WD_HI) begin
      wd_period[WD_W-1:DATA_W] <= reg_wdata_in;
    end
  end

  assign wd_start = wr_hit && reg_addr_in == ADR_CTRL
                    && reg_wdata_in[CTRL_WD_START];

  vim_watchdog #(
    .TICK_CYC (WD_TICK)
  ) u_wd (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .start_in    (wd_start),
    .period_in   (wd_period),
    .running_out (wd_run),
    .half_out    (wd_half),
    .expire_out  (wd_expire)
  );

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wd_reset_n_out <= 1'b1;
    end else begin
      wd_reset_n_out <= !wd_expire;
    end
  end

  // Sticky events; a set in the clearing cycle survives
  assign evt_set[EV_MBOX] = mbox_evt;
  assign evt_set[EV_WD] = wd_half;
  assign evt_set[EV_ABORT] = abort_act;
  assign evt_set[EV_SYSFAIL] = !sysfail_act;
  assign evt_set[EV_ACFAIL] = acfail_act;
  assign evt_clr = (wr_hit && reg_addr_in == ADR_STATUS)
                   ? reg_wdata_in[EVT_W-1:0] : '0;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status <= '0;
    end else begin
      status <= (status & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask <= '0;
    end else if (wr_hit && reg_addr_in == ADR_MASK) begin
      mask <= reg_wdata_in[EVT_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status & mask);
    end
  end

  // Host lines: forwarded levels plus the mailbox when mapped there
  always_comb begin
    next_host_n = '1;
    for (int n = 1; n <= LEVELS; n++) begin
      if (fwd_en[n] && vme_req[n]) begin
        next_host_n[n] = 1'b0;
      end
      if (status[EV_MBOX] && mbox_map == MAP_W'(n)) begin
        next_host_n[n] = 1'b0;
      end
    end
  end

  // Pending mailbox holds its line low until cleared
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_irq_line_n_out <= '1;
    end else begin
      host_irq_line_n_out <= next_host_n;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mailbox_special_irq_n_out <= 1'b1;
      mbox_reset_n_out <= 1'b1;
    end else begin
      mailbox_special_irq_n_out <= !(status[EV_MBOX] && mbox_map == RST_MAP
                                     && !strap_reset);
      mbox_reset_n_out <= !(status[EV_MBOX] && mbox_map == RST_MAP
                            && strap_reset);
    end
  end

  // Watchdog, abort, SYSFAIL and ACFAIL events make the non-maskable source; the mailbox is not one
  assign nmi_src = status[EV_WD] || status[EV_ABORT]
                   || status[EV_SYSFAIL] || status[EV_ACFAIL];

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nmi_n_out <= 1'b1;
    end else begin
      nmi_n_out <= !(nmi_en && nmi_src);
    end
  end

  // Read data only in the cycle after the strobe
  always_comb begin
    next_rdata = '0;
    case (reg_addr_in)
      ADR_MAILBOX: next_rdata = mailbox;
      ADR_MAP: next_rdata[MAP_W-1:0] = mbox_map;
      ADR_CTRL: begin
        next_rdata[CTRL_FAIR] = fair_mode;
        next_rdata[CTRL_NMI_EN] = nmi_en;
      end
      ADR_RERUN: next_rdata[RERUN_W-1:0] = rerun;
      ADR_WD_LO: next_rdata = wd_period[DATA_W-1:0];
      ADR_WD_HI: next_rdata = wd_period[WD_W-1:DATA_W];
      ADR_STATUS: next_rdata[EVT_W-1:0] = status;
      ADR_MASK: next_rdata[EVT_W-1:0] = mask;
      ADR_STATE: begin
        next_rdata[ST_WD_RUN] = wd_run;
        next_rdata[ST_STRAP] = strap_reset;
        next_rdata[ST_SF_DRIVE] = sf_drive;
      end
      default: begin
        for (int n = 1; n <= LEVELS; n++) begin
          if (reg_addr_in == ADR_FWD_BASE + ADDR_W'(n)) begin
            next_rdata = fwd_cfg[n];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= reg_rd_in ? next_rdata : '0;
    end
  end
endmodule

//--- vim_router_props.sv
`timescale 1ns/1ns
module vim_router_props
  import vim_pkg::*;
(
  input wire logic                       clk_sys_in,
  input wire logic                       rst_n_in,
  input wire logic [vim_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [vim_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic                       reg_wr_in,
  input wire logic                       reg_rd_in,
  input wire logic [vim_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic                       vme_mbox_acc_in,
  input wire logic                       mbox_strap_in,
  input wire logic [vim_pkg::LEVELS:1]   host_irq_line_n_out,
  input wire logic                       mailbox_special_irq_n_out,
  input wire logic                       mbox_reset_n_out,
  input wire logic                       nmi_n_out,
  input wire logic                       wd_reset_n_out,
  input wire logic                       req_fair_out,
  input wire logic                       sysfail_n_out,
  input wire logic                       sysfail_oe_n_out
);
  import vim_pkg::*;
  logic             nmi_en;
  logic             fair_sh;
  logic             wd_go;
  logic [MAP_W-1:0] map_sh;
  logic             ctrl_wr;
  assign ctrl_wr = reg_wr_in && (reg_addr_in == ADR_CTRL);
  // Shadows of the control bits, seen only through bus writes
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nmi_en <= RST_NMI_EN;
      fair_sh <= RST_FAIR;
      wd_go <= 1'b0;
    end else if (ctrl_wr) begin
      nmi_en <= reg_wdata_in[CTRL_NMI_EN];
      fair_sh <= reg_wdata_in[CTRL_FAIR];
      wd_go <= wd_go | reg_wdata_in[CTRL_WD_START];
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      map_sh <= RST_MAP;
    end else if (reg_wr_in && (reg_addr_in == ADR_MAP)) begin
      map_sh <= reg_wdata_in[MAP_W-1:0];
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence mbox_hit;
    $rose(vme_mbox_acc_in);
  endsequence
  // Two sync edges, status, then the line: three edges after the sampled rise
  property mbox_to_line;
    mbox_hit ##0 (map_sh != 3'h0) |-> ##[2:4] !host_irq_line_n_out[map_sh];
  endproperty
  property mbox_to_special;
    mbox_hit ##0 (map_sh == 3'h0)
      |-> ##[2:4] !(mbox_strap_in ? mbox_reset_n_out : mailbox_special_irq_n_out);
  endproperty
  a_mbox_line: assert property (mbox_to_line)
    else $error("mailbox line not asserted");
  a_mbox_zero: assert property (mbox_to_special)
    else $error("mapping zero output not asserted");
  a_nmi_gated: assert property (!nmi_en |=> nmi_n_out)
    else $error("nmi raised while disabled");
  a_fair_follow: assert property ($stable(fair_sh) [*2] |-> req_fair_out == fair_sh)
    else $error("fair mode output wrong");
  a_sf_release: assert property (ctrl_wr && reg_wdata_in[CTRL_SF_REL] |-> ##[1:2] sysfail_oe_n_out)
    else $error("sysfail not released");
  a_sf_drive: assert property (!sysfail_oe_n_out |-> !sysfail_n_out)
    else $error("sysfail driven high");
  a_wd_quiet: assert property (!wd_go |-> wd_reset_n_out)
    else $error("watchdog fired before start");
  a_wd_pulse: assert property (!wd_reset_n_out |=> wd_reset_n_out)
    else $error("watchdog pulse too long");
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == '0)
    else $error("read data outside read cycle");
endmodule

bind vim_router vim_router_props vim_router_props_i (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .vme_mbox_acc_in(vme_mbox_acc_in),
  .mbox_strap_in(mbox_strap_in), .host_irq_line_n_out(host_irq_line_n_out),
  .mailbox_special_irq_n_out(mailbox_special_irq_n_out),
  .mbox_reset_n_out(mbox_reset_n_out), .nmi_n_out(nmi_n_out),
  .wd_reset_n_out(wd_reset_n_out), .req_fair_out(req_fair_out),
  .sysfail_n_out(sysfail_n_out), .sysfail_oe_n_out(sysfail_oe_n_out));

//--- vim_vme_model.sv
`timescale 1ns/1ns
module vim_vme_model
  import vim_pkg::*;
(
  input  wire logic                       clk_in,
  output logic      [vim_pkg::LEVELS:1]   irq_n_out,
  output logic                            acc_out,
  output logic                            we_out,
  output logic      [vim_pkg::DATA_W-1:0] wdata_out
);
  import vim_pkg::*;
  initial begin
    irq_n_out = '1;
    acc_out = 1'b0;
    we_out = 1'b0;
    wdata_out = 8'h00;
  end
  // Interrupter holds its level until told to let go
  task automatic set_irq(input int lvl, input logic v);
    @(posedge clk_in);
    irq_n_out[lvl] <= v;
  endtask
  // Three cycles high, three idle, so the next access is seen as new
  task automatic access(input logic w, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    acc_out <= 1'b1;
    we_out <= w;
    wdata_out <= d;
    repeat (3) @(posedge clk_in);
    acc_out <= 1'b0;
    we_out <= ~w;
    wdata_out <= ~d;
    repeat (3) @(posedge clk_in);
  endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import vim_pkg::*;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic               wr_stb = 1'b0;
  logic               rd_stb = 1'b0;
  logic               strap = 1'b0;
  logic               abort_n = 1'b1;
  logic               acfail_n = 1'b1;
  logic [ADDR_W-1:0]  addr = '0;
  logic [DATA_W-1:0]  wdata = '0;
  logic [DATA_W-1:0]  rdata, mb_rdata, mb_wdata;
  logic [LEVELS:1]    virq_n, hirq_n;
  logic [RERUN_W-1:0] rerun;
  logic               acc, we, sf_n, sf_oe_n, spec_n, mrst_n, nmi_n, wdr_n, fair, irq;
  int                 failures = 0;
  int                 comparisons = 0;
  int                 n;
  wire                sf_bus = sf_oe_n ? 1'b1 : sf_n;
  always #10 clk_sys = ~clk_sys;
  // Tick of one cycle keeps the watchdog period short
  vim_router #(.WD_TICK(1)) vim_router_i (
    .clk_sys_in(clk_sys), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr_stb), .reg_rd_in(rd_stb), .reg_rdata_out(rdata), .vme_irq_n_in(virq_n),
    .vme_mbox_acc_in(acc), .vme_mbox_we_in(we), .vme_mbox_wdata_in(mb_wdata),
    .vme_mbox_rdata_out(mb_rdata), .abort_n_in(abort_n), .acfail_n_in(acfail_n),
    .sysfail_n_in(sf_bus), .sysfail_n_out(sf_n), .sysfail_oe_n_out(sf_oe_n),
    .mbox_strap_in(strap), .host_irq_line_n_out(hirq_n), .mailbox_special_irq_n_out(spec_n),
    .mbox_reset_n_out(mrst_n), .nmi_n_out(nmi_n), .wd_reset_n_out(wdr_n),
    .req_fair_out(fair), .rerun_count_out(rerun), .irq_out(irq));
  vim_vme_model vim_vme_model_i (.clk_in(clk_sys), .irq_n_out(virq_n), .acc_out(acc),
    .we_out(we), .wdata_out(mb_wdata));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Outputs are looked at mid-cycle, clear of the edge updates
  task automatic settle(input int c);
    repeat (c) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask
  task automatic bus_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_sys);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(negedge clk_sys);
    chk(rdata, e);
  endtask
  task automatic t_reset;
    settle(2);
    chk({7'h0, sf_oe_n}, 8'h00);
    chk({7'h0, fair}, 8'h01);
    chk({3'h0, rerun}, 8'h00);
    bus_rd(ADR_MAP, 8'h00);
    bus_rd(ADR_FWD_BASE + 4'h1, 8'hFF);
    bus_rd(ADR_CTRL, 8'h03);
    bus_rd(ADR_STATE, 8'h04);
    bus_wr(ADR_CTRL, 8'h0B);
    settle(4);
    bus_wr(ADR_STATUS, 8'h1F);
    settle(2);
    chk({7'h0, sf_oe_n}, 8'h01);
    chk({7'h0, nmi_n}, 8'h01);
    bus_rd(ADR_STATE, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_regs;
    bus_wr(ADR_RERUN, 8'hFF);
    bus_rd(ADR_RERUN, 8'h1F);
    chk({3'h0, rerun}, 8'h1F);
    bus_wr(ADR_MAP, 8'hFD);
    bus_rd(ADR_MAP, 8'h05);
    bus_wr(ADR_MAILBOX, 8'hA5);
    bus_rd(ADR_MAILBOX, 8'hA5);
    chk(mb_rdata, 8'hA5);
    bus_wr(ADR_CTRL, 8'h02);
    settle(2);
    chk({7'h0, fair}, 8'h00);
    bus_wr(ADR_CTRL, 8'h03);
    $display("register test done");
  endtask
  task automatic t_fwd;
    for (int l = 1; l <= 7; l++) begin
      bus_wr(ADR_FWD_BASE + 4'(l), 8'hFF);
      vim_vme_model_i.set_irq(l, 1'b0);
      settle(4);
      chk({hirq_n, 1'b1}, 8'hFF);
      bus_wr(ADR_FWD_BASE + 4'(l), 8'h08 | 8'(l));
      settle(4);
      chk({hirq_n, 1'b1}, ~(8'h01 << l));
      vim_vme_model_i.set_irq(l, 1'b1);
      settle(4);
      chk({hirq_n, 1'b1}, 8'hFF);
    end
    $display("forwarding test done");
  endtask
  task automatic t_mbox;
    bus_wr(ADR_MASK, 8'h01);
    for (int m = 0; m < 8; m++) begin
      bus_wr(ADR_MAP, 8'(m));
      vim_vme_model_i.access(1'b1, 8'h30 + 8'(m));
      settle(1);
      chk({hirq_n, spec_n}, ~(8'h01 << m));
      chk({7'h0, irq}, 8'h01);
      bus_rd(ADR_MAILBOX, 8'h30 + 8'(m));
      bus_wr(ADR_STATUS, 8'h01);
      settle(2);
      chk({hirq_n, spec_n}, 8'hFF);
      chk({7'h0, irq}, 8'h00);
    end
    bus_wr(ADR_MASK, 8'h00);
    vim_vme_model_i.access(1'b0, 8'h00);
    settle(1);
    chk({7'h0, irq}, 8'h00);
    bus_rd(ADR_STATUS, 8'h01);
    bus_rd(ADR_MAILBOX, 8'h37);
    bus_wr(ADR_STATUS, 8'h01);
    $display("mailbox test done");
  endtask
  task automatic t_nmi;
    for (int e = 1; e >= 0; e--) begin
      bus_wr(ADR_CTRL, 8'h01 | 8'(e << 1));
      abort_n <= 1'b0;
      settle(4);
      chk({7'h0, nmi_n}, 8'(e == 0));
      @(posedge clk_sys);
      abort_n <= 1'b1;
      settle(4);
      bus_rd(ADR_STATUS, 8'h04);
      bus_wr(ADR_STATUS, 8'h04);
      acfail_n <= 1'b0;
      settle(4);
      chk({7'h0, nmi_n}, 8'(e == 0));
      @(posedge clk_sys);
      acfail_n <= 1'b1;
      settle(4);
      bus_rd(ADR_STATUS, 8'h10);
      bus_wr(ADR_STATUS, 8'h1F);
    end
    bus_wr(ADR_CTRL, 8'h03);
    $display("nmi test done");
  endtask
  task automatic t_wd;
    bus_wr(ADR_WD_LO, 8'h10);
    bus_wr(ADR_WD_HI, 8'h00);
    settle(40);
    bus_rd(ADR_STATE, 8'h00);
    bus_wr(ADR_CTRL, 8'h07);
    bus_wr(ADR_CTRL, 8'h03);
    settle(2);
    bus_rd(ADR_STATE, 8'h01);
    n = 0;
    while (wdr_n === 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk({7'h0, wdr_n}, 8'h00);
    bus_rd(ADR_STATUS, 8'h02);
    chk({7'h0, nmi_n}, 8'h00);
    $display("watchdog test done");
  endtask
  task automatic t_strap;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    strap <= 1'b1;
    settle(2);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    settle(4);
    bus_rd(ADR_STATE, 8'h06);
    vim_vme_model_i.access(1'b1, 8'h5A);
    settle(1);
    chk({6'h0, mrst_n, spec_n}, 8'h01);
    $display("strap test done");
  endtask
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_fwd;
    t_mbox;
    t_nmi;
    t_wd;
    t_strap;
    end_sim;
  end
  // Whole run needs about five hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    end_sim;
  end
endmodule
